/* File: logic/sgc_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module sgc_regs #(
  parameter int                        NPORTS           = 3,
  parameter logic [sgc_pkg::TMR_W-1:0] INTERVAL_100_CYC = sgc_pkg::STORM_T100_CYC,
  parameter logic [sgc_pkg::TMR_W-1:0] INTERVAL_10_CYC  = sgc_pkg::STORM_T10_CYC
) (
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  output logic      [7:0]                  reg_rdata,
  output logic                             reg_rvalid,
  input  wire logic                        strap_led_hi,
  input  wire logic                        strap_led_lo,
  output logic      [1:0]                  led_mode,
  output logic                             test_mode,
  output logic                             direct_forward_tag_mode,
  output logic      [sgc_pkg::LIMIT_W-1:0] storm_limit,
  input  wire logic [NPORTS-1:0]           port_storm_en,
  input  wire logic [NPORTS-1:0]           port_speed_10,
  input  wire logic [NPORTS-1:0]           blk_accept,
  input  wire logic [NPORTS-1:0]           blk_bcast,
  output logic      [NPORTS-1:0]           bcast_drop,
  input  wire logic                        tag_valid,
  input  wire logic [sgc_pkg::PCP_W-1:0]   tag_pcp,
  output logic                             prio_valid,
  output logic      [sgc_pkg::PRIO_W-1:0]  prio
);

  // Register state
  logic [sgc_pkg::STORM_HI_W-1:0] storm_hi_q;
  logic [sgc_pkg::STORM_HI_W-1:0] storm_hi_d;
  logic [7:0]                     storm_lo_q;
  logic [7:0]                     storm_lo_d;
  logic [7:0]                     ft_a_q;
  logic [7:0]                     ft_a_d;
  logic [7:0]                     ft_b_q;
  logic [7:0]                     ft_b_d;
  logic [7:0]                     ft_c_q;
  logic [7:0]                     ft_c_d;
  logic [7:0]                     led_ctrl_q;
  logic [7:0]                     led_ctrl_d;
  logic [7:0]                     pmap_lo_q;
  logic [7:0]                     pmap_lo_d;
  logic [7:0]                     pmap_hi_q;
  logic [7:0]                     pmap_hi_d;

  // Strap capture
  logic [1:0]                     strap_meta_q;
  logic [1:0]                     strap_sync_q;
  logic                           strap_done_q;
  logic                           strap_done_d;

  // Read port
  logic [7:0]                     rdata_q;
  logic [7:0]                     rdata_d;
  logic                           rvalid_q;
  logic                           rvalid_d;

  // Priority lookup
  logic [15:0]                    pmap_all;
  logic [15:0]                    pmap_shift;
  logic [sgc_pkg::PRIO_W-1:0]     prio_q;
  logic [sgc_pkg::PRIO_W-1:0]     prio_d;
  logic                           prio_valid_q;
  logic                           prio_valid_d;

  logic [sgc_pkg::LIMIT_W-1:0]    limit_q;
  logic [sgc_pkg::LIMIT_W-1:0]    limit_d;

  // Strap synchroniser runs without reset so it follows the pins
  // during reset; the first edge after release then sees a settled value.
  always_ff @(posedge clock) begin
    strap_meta_q <= {strap_led_hi, strap_led_lo};
    strap_sync_q <= strap_meta_q;
  end

  always_comb begin
    strap_done_d = 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_q <= 1'b0;
    end else begin
      strap_done_q <= strap_done_d;
    end
  end

  // Register writes
  always_comb begin
    storm_hi_d = storm_hi_q;
    storm_lo_d = storm_lo_q;
    ft_a_d     = ft_a_q;
    ft_b_d     = ft_b_q;
    ft_c_d     = ft_c_q;
    led_ctrl_d = led_ctrl_q;
    pmap_lo_d  = pmap_lo_q;
    pmap_hi_d  = pmap_hi_q;
    if (reg_wr) begin
      case (reg_addr)
        sgc_pkg::ADDR_STORM_HI: begin
          storm_hi_d = reg_wdata[sgc_pkg::STORM_HI_W-1:0];
        end
        sgc_pkg::ADDR_STORM_LO: begin
          storm_lo_d = reg_wdata;
        end
        sgc_pkg::ADDR_FT_A: begin
          ft_a_d = reg_wdata;
        end
        sgc_pkg::ADDR_FT_B: begin
          ft_b_d = reg_wdata;
        end
        sgc_pkg::ADDR_FT_C: begin
          ft_c_d = reg_wdata;
        end
        sgc_pkg::ADDR_LED_CTRL: begin
          led_ctrl_d = reg_wdata;
        end
        sgc_pkg::ADDR_PMAP_LO: begin
          pmap_lo_d = reg_wdata;
        end
        sgc_pkg::ADDR_PMAP_HI: begin
          pmap_hi_d = reg_wdata;
        end
        default: begin
          storm_hi_d = storm_hi_q;
        end
      endcase
    end
    // Strap load wins over a write in the first cycle after release
    if (!strap_done_q) begin
      led_ctrl_d[sgc_pkg::LED_HI_BIT] = strap_sync_q[1];
      led_ctrl_d[sgc_pkg::LED_LO_BIT] = strap_sync_q[0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      storm_hi_q <= sgc_pkg::RST_STORM_HI;
      storm_lo_q <= sgc_pkg::RST_STORM_LO;
      ft_a_q     <= sgc_pkg::RST_FT_A;
      ft_b_q     <= sgc_pkg::RST_FT_B;
      ft_c_q     <= sgc_pkg::RST_FT_C;
      led_ctrl_q <= sgc_pkg::RST_LED_CTRL;
      pmap_lo_q  <= sgc_pkg::RST_PMAP_LO;
      pmap_hi_q  <= sgc_pkg::RST_PMAP_HI;
    end else begin
      storm_hi_q <= storm_hi_d;
      storm_lo_q <= storm_lo_d;
      ft_a_q     <= ft_a_d;
      ft_b_q     <= ft_b_d;
      ft_c_q     <= ft_c_d;
      led_ctrl_q <= led_ctrl_d;
      pmap_lo_q  <= pmap_lo_d;
      pmap_hi_q  <= pmap_hi_d;
    end
  end

  // Register reads, one cycle after the strobe
  always_comb begin
    rvalid_d = reg_rd;
    rdata_d  = rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        sgc_pkg::ADDR_STORM_HI: begin
          // Upper bits of this address belong to a neighbouring block
          rdata_d = {5'h00, storm_hi_q};
        end
        sgc_pkg::ADDR_STORM_LO: begin
          rdata_d = storm_lo_q;
        end
        sgc_pkg::ADDR_FT_A: begin
          rdata_d = ft_a_q;
        end
        sgc_pkg::ADDR_FT_B: begin
          rdata_d = ft_b_q;
        end
        sgc_pkg::ADDR_FT_C: begin
          rdata_d = ft_c_q;
        end
        sgc_pkg::ADDR_LED_CTRL: begin
          rdata_d = led_ctrl_q;
        end
        sgc_pkg::ADDR_PMAP_LO: begin
          rdata_d = pmap_lo_q;
        end
        sgc_pkg::ADDR_PMAP_HI: begin
          rdata_d = pmap_hi_q;
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // 802.1p code to internal priority; codes 4-7 sit in the upper byte
  assign pmap_all   = {pmap_hi_q, pmap_lo_q};
  assign pmap_shift = pmap_all >> {tag_pcp, 1'b0};

  always_comb begin
    prio_valid_d = tag_valid;
    prio_d       = prio_q;
    if (tag_valid) begin
      prio_d = pmap_shift[sgc_pkg::PRIO_W-1:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prio_q       <= '0;
      prio_valid_q <= 1'b0;
    end else begin
      prio_q       <= prio_d;
      prio_valid_q <= prio_valid_d;
    end
  end

  // Limit is registered so the storm counters see a stable value
  always_comb begin
    limit_d = {storm_hi_q, storm_lo_q};
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      limit_q <= {sgc_pkg::RST_STORM_HI, sgc_pkg::RST_STORM_LO};
    end else begin
      limit_q <= limit_d;
    end
  end

  // One interval timer per port, since each port has its own speed
  genvar gi;
  generate
    for (gi = 0; gi < NPORTS; gi++) begin : g_port
      sgc_storm_port #(
        .INTERVAL_100_CYC (INTERVAL_100_CYC),
        .INTERVAL_10_CYC  (INTERVAL_10_CYC)
      ) u_storm (
        .clock      (clock),
        .rst_n      (rst_n),
        .storm_en   (port_storm_en[gi]),
        .speed_10   (port_speed_10[gi]),
        .blk_accept (blk_accept[gi]),
        .blk_bcast  (blk_bcast[gi]),
        .limit      (limit_q),
        .drop_q     (bcast_drop[gi])
      );
    end
  endgenerate

  assign reg_rdata               = rdata_q;
  assign reg_rvalid              = rvalid_q;
  assign led_mode                = {led_ctrl_q[sgc_pkg::LED_HI_BIT], led_ctrl_q[sgc_pkg::LED_LO_BIT]};
  // Exposed so neighbouring logic can enter test behaviour
  assign test_mode               = led_ctrl_q[sgc_pkg::TEST_BIT];
  assign direct_forward_tag_mode = led_ctrl_q[sgc_pkg::DFT_BIT];
  assign storm_limit             = limit_q;
  assign prio                    = prio_q;
  assign prio_valid              = prio_valid_q;

endmodule // sgc_regs
`default_nettype wire

/* File: logic/sgc_pkg.sv */
// What this block does
// - Storm limit is 11 bits: three upper bits plus this low byte, in 64-byte blocks.
// - Storm interval lasts 67 ms at 100 Mbps and 500 ms at 10 Mbps.
// - Storm limit low byte resets to 0x63, about one percent of 100 Mbps.
// - Upper three limit bits come from bits 2-0 of register 0x06, reset zero.
// - Three factory-test registers at 0x08-0x0A reset to 0x00, 0x24, 0x35.
// - LED mode is bits 7 and 1 of LED control; it picks LED meaning.
// - Both LED mode bits load from strap pins at reset, then software-writable.
// - LED control bit 0 enables direct-forward tag mode for port 3; resets zero.
// - Tagged frame priority comes from the two-bit field for its priority code.
// - Codes 0 and 1 reset to priority 00, codes 2 and 3 to 01.
// - Codes 4-7 map from register 0x0D; reset 10, 10, 11, 11.
package sgc_pkg;

  localparam logic [7:0] ADDR_STORM_HI  = 8'h06;
  localparam logic [7:0] ADDR_STORM_LO  = 8'h07;
  localparam logic [7:0] ADDR_FT_A      = 8'h08;
  localparam logic [7:0] ADDR_FT_B      = 8'h09;
  localparam logic [7:0] ADDR_FT_C      = 8'h0a;
  localparam logic [7:0] ADDR_LED_CTRL  = 8'h0b;
  localparam logic [7:0] ADDR_PMAP_LO   = 8'h0c;
  localparam logic [7:0] ADDR_PMAP_HI   = 8'h0d;

  localparam logic [2:0] RST_STORM_HI   = 3'h0;
  localparam logic [7:0] RST_STORM_LO   = 8'h63;
  localparam logic [7:0] RST_FT_A       = 8'h00;
  localparam logic [7:0] RST_FT_B       = 8'h24;
  localparam logic [7:0] RST_FT_C       = 8'h35;
  // Strap bits 7 and 1 read as zero here, loaded after release
  localparam logic [7:0] RST_LED_CTRL   = 8'h08;
  localparam logic [7:0] RST_PMAP_LO    = 8'h50;
  localparam logic [7:0] RST_PMAP_HI    = 8'hfa;

  localparam int STORM_HI_W   = 3;
  localparam int LIMIT_W      = 11;
  localparam int BLOCK_BYTES  = 64;
  localparam int LED_HI_BIT   = 7;
  localparam int TEST_BIT     = 4;
  localparam int LED_LO_BIT   = 1;
  localparam int DFT_BIT      = 0;
  localparam int PRIO_W       = 2;
  localparam int PCP_W        = 3;

  localparam int CLK_HZ        = 20_000_000;
  localparam int STORM_T100_MS = 67;
  localparam int STORM_T10_MS  = 500;
  localparam int TMR_W         = 24;
  localparam logic [TMR_W-1:0] STORM_T100_CYC = TMR_W'(STORM_T100_MS * (CLK_HZ / 1000));
  localparam logic [TMR_W-1:0] STORM_T10_CYC  = TMR_W'(STORM_T10_MS * (CLK_HZ / 1000));

endpackage

/* File: logic/sgc_storm_port.sv */
`timescale 1ns/1ps
`default_nettype none
module sgc_storm_port #(
  parameter logic [sgc_pkg::TMR_W-1:0] INTERVAL_100_CYC = sgc_pkg::STORM_T100_CYC,
  parameter logic [sgc_pkg::TMR_W-1:0] INTERVAL_10_CYC  = sgc_pkg::STORM_T10_CYC
) (
  input  wire logic                         clock,
  input  wire logic                         rst_n,
  input  wire logic                         storm_en,
  input  wire logic                         speed_10,
  input  wire logic                         blk_accept,
  input  wire logic                         blk_bcast,
  input  wire logic [sgc_pkg::LIMIT_W-1:0]  limit,
  output logic                              drop_q
);

  logic [sgc_pkg::TMR_W-1:0]   tmr_q;
  logic [sgc_pkg::TMR_W-1:0]   tmr_d;
  logic [sgc_pkg::LIMIT_W-1:0] cnt_q;
  logic [sgc_pkg::LIMIT_W-1:0] cnt_d;
  logic                        drop_d;
  logic                        boundary;
  logic                        discard;

  assign boundary = (tmr_q == '0);
  // A dropped block was never accepted, so it is not counted
  assign discard  = blk_bcast && drop_q;

  always_comb begin
    tmr_d  = tmr_q - 1'b1;
    cnt_d  = cnt_q;
    if (boundary) begin
      // Speed is sampled only here; a change takes effect next interval
      tmr_d = speed_10 ? (INTERVAL_10_CYC - 1'b1) : (INTERVAL_100_CYC - 1'b1);
      cnt_d = '0;
    end else if (blk_accept && !discard && (cnt_q != '1)) begin
      cnt_d = cnt_q + 1'b1;
    end
    drop_d = storm_en && (cnt_d >= limit);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tmr_q  <= '0;
      cnt_q  <= '0;
      drop_q <= 1'b0;
    end else begin
      tmr_q  <= tmr_d;
      cnt_q  <= cnt_d;
      drop_q <= drop_d;
    end
  end

endmodule // sgc_storm_port
`default_nettype wire

/* File: tb/sgc_regs_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sgc_regs_properties #(
  parameter int NPORTS = 3
) (
  input wire logic                         clock,
  input wire logic                         rst_n,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [7:0]                   reg_addr,
  input wire logic [7:0]                   reg_wdata,
  input wire logic                         reg_rvalid,
  input wire logic [1:0]                   led_mode,
  input wire logic                         direct_forward_tag_mode,
  input wire logic [sgc_pkg::LIMIT_W-1:0]  storm_limit,
  input wire logic [NPORTS-1:0]            port_storm_en,
  input wire logic [NPORTS-1:0]            bcast_drop,
  input wire logic                         tag_valid,
  input wire logic                         prio_valid,
  input wire logic [sgc_pkg::PRIO_W-1:0]   prio
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Straps win the first edge after release, so that edge is excluded
  // A sequence, since an implication needs one on its left side
  sequence p_wr(logic [7:0] a);
    reg_wr && reg_addr == a && $past(rst_n);
  endsequence
  a_rvalid_after_rd: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  a_rvalid_has_rd: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray read answer");
  a_led_mode_wr: assert property (p_wr(sgc_pkg::ADDR_LED_CTRL) |=>
    led_mode == {$past(reg_wdata[7]), $past(reg_wdata[1])}) else $error("led mode not from write");
  a_dft_mode_wr: assert property (p_wr(sgc_pkg::ADDR_LED_CTRL) |=>
    direct_forward_tag_mode == $past(reg_wdata[0])) else $error("tag mode not from write");
  a_limit_low_wr: assert property (p_wr(sgc_pkg::ADDR_STORM_LO) |-> ##2
    storm_limit[7:0] == $past(reg_wdata, 2)) else $error("limit low byte wrong");
  a_limit_high_wr: assert property (p_wr(sgc_pkg::ADDR_STORM_HI) |-> ##2
    storm_limit[10:8] == $past(reg_wdata[2:0], 2)) else $error("limit high bits wrong");
  a_prio_answer: assert property (tag_valid |=> prio_valid) else $error("lookup not answered");
  a_prio_holds: assert property (!prio_valid |-> $stable(prio)) else $error("prio moved without lookup");
  a_drop_needs_en: assert property (!port_storm_en[0] |=> !bcast_drop[0]) else $error("drop while off");
  c_led_write: cover property (p_wr(sgc_pkg::ADDR_LED_CTRL));
  c_drop_seen: cover property ($rose(bcast_drop[0]));
  c_lookup_b2b: cover property (tag_valid ##1 tag_valid);
endmodule // sgc_regs_properties
bind sgc_regs sgc_regs_properties #(.NPORTS(NPORTS)) u_props (.clock(clock), .rst_n(rst_n),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid),
  .led_mode(led_mode), .direct_forward_tag_mode(direct_forward_tag_mode), .storm_limit(storm_limit),
  .port_storm_en(port_storm_en), .bcast_drop(bcast_drop), .tag_valid(tag_valid),
  .prio_valid(prio_valid), .prio(prio));
`default_nettype wire

/* File: tb/sgc_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sgc_regs_tb;
  logic        clock, rst_n, reg_wr, reg_rd, tag_valid, prio_valid, reg_rvalid, test_mode, dft;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [2:0]  en, spd, bacc, bbc, drop, pcp;
  logic [1:0]  led_mode, prio;
  logic [10:0] storm_limit;
  logic        s_hi, s_lo;
  int          n_errors, n_tests;
  sgc_regs #(.NPORTS(3), .INTERVAL_100_CYC(24'h00_0014), .INTERVAL_10_CYC(24'h00_0032)) dut_u (
    .clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .strap_led_hi(s_hi),
    .strap_led_lo(s_lo), .led_mode(led_mode), .test_mode(test_mode), .direct_forward_tag_mode(dft),
    .storm_limit(storm_limit), .port_storm_en(en), .port_speed_10(spd), .blk_accept(bacc),
    .blk_bcast(bbc), .bcast_drop(drop), .tag_valid(tag_valid), .tag_pcp(pcp),
    .prio_valid(prio_valid), .prio(prio));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rvalid, 1);
    chk(reg_rdata, exp);
  endtask
  task automatic lk(input logic [2:0] p, input logic [1:0] exp);
    @(posedge clock);
    tag_valid <= 1'b1;
    pcp <= p;
    @(posedge clock);
    tag_valid <= 1'b0;
    #1;
    chk(prio_valid, 1);
    chk(prio, exp);
  endtask
  // Bounded wait on port 0 drop level, counting cycles taken
  task automatic wait_drop(input logic lvl, output int n);
    n = 0;
    // Step off the edge so drop is read settled
    #1;
    while (drop[0] !== lvl) begin
      @(posedge clock);
      #1;
      n++;
      if (n > 80) begin
        n_errors++;
        complete_run();
      end
    end
  endtask
  task automatic t_reset();
    logic [7:0] exp [8] = '{8'h00, 8'h63, 8'h00, 8'h24, 8'h35, 8'h88, 8'h50, 8'hfa};
    for (int i = 0; i < 8; i++) rd(sgc_pkg::ADDR_STORM_HI + 8'(i), exp[i]);
    chk(led_mode, 2'b10);
    chk(storm_limit, 11'h063);
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_led();
    wr(sgc_pkg::ADDR_LED_CTRL, 8'h83);
    chk({led_mode, dft}, 3'b111);
    wr(sgc_pkg::ADDR_LED_CTRL, 8'h02);
    chk({led_mode, dft, test_mode}, 4'b0100);
    rd(sgc_pkg::ADDR_LED_CTRL, 8'h02);
    $display("test led done");
  endtask
  task automatic t_prio();
    for (int p = 0; p < 8; p++) lk(3'(p), 2'(p / 2));
    wr(sgc_pkg::ADDR_PMAP_LO, 8'he4);
    wr(sgc_pkg::ADDR_PMAP_HI, 8'h1b);
    for (int p = 0; p < 8; p++) lk(3'(p), p < 4 ? 2'(p) : 2'(7 - p));
    $display("test prio done");
  endtask
  // Limit register lags the byte registers by one edge
  task automatic t_limit();
    wr(sgc_pkg::ADDR_STORM_HI, 8'hfd);
    rd(sgc_pkg::ADDR_STORM_HI, 8'h05);
    wr(sgc_pkg::ADDR_STORM_LO, 8'h02);
    @(posedge clock);
    #1;
    chk(storm_limit, 11'h502);
    wr(sgc_pkg::ADDR_STORM_HI, 8'h00);
    repeat (2) @(posedge clock);
    $display("test limit done");
  endtask
  // Measure how long drop stands once the limit is hit right after a boundary
  task automatic t_storm(input logic s, input int lo, input int hi);
    int n;
    @(posedge clock);
    spd <= {2'b00, s};
    en <= 3'b001;
    bacc <= 3'b001;
    wait_drop(1'b1, n);
    chk(drop[2:1], 2'b00);
    @(posedge clock);
    bacc <= 3'b000;
    wait_drop(1'b0, n);
    @(posedge clock);
    bacc <= 3'b001;
    wait_drop(1'b1, n);
    chk(n <= 5, 1);
    @(posedge clock);
    bacc <= 3'b000;
    wait_drop(1'b0, n);
    chk(n >= lo && n <= hi, 1);
    $display("test storm speed %0d done", s);
  endtask
  initial begin
    {rst_n, reg_wr, reg_rd, tag_valid, s_lo} = 5'h00;
    {reg_addr, reg_wdata, en, spd, bacc, pcp} = 28'h000_0000;
    bbc = 3'b111;
    s_hi = 1'b1;
    n_errors = 0;
    n_tests = 0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    t_reset();
    t_led();
    t_prio();
    t_limit();
    t_storm(1'b0, 12, 21);
    t_storm(1'b1, 42, 51);
    complete_run();
  end
endmodule // sgc_regs_tb
`default_nettype wire
